/* File: common/lpctf_pkg.sv */
package lpctf_pkg;

	// ----------------------------------------------------------------
	// Bus field encodings
	// ----------------------------------------------------------------
	localparam logic [3:0] START_NIB  = 4'h0;
	localparam logic [1:0] CT_IO      = 2'h0;
	localparam logic [1:0] CT_DMA     = 2'h2;
	localparam int         CT_KIND_HI = 3;
	localparam int         CT_KIND_LO = 2;
	localparam int         CT_DIR_BIT = 1;
	localparam int         CH_TC_BIT  = 3;
	localparam logic [3:0] TAR_NIB    = 4'hF;

	// ----------------------------------------------------------------
	// Handshake codes driven by the target
	// ----------------------------------------------------------------
	localparam logic [3:0] SYNC_READY = 4'h0;
	localparam logic [3:0] SYNC_SHORT = 4'h5;
	localparam logic [3:0] SYNC_LONG  = 4'h6;
	localparam logic [3:0] SYNC_MORE  = 4'h9;
	localparam logic [3:0] SYNC_ERR   = 4'hA;

	// ----------------------------------------------------------------
	// DMA size field and byte counts (bytes left after the current one)
	// ----------------------------------------------------------------
	localparam logic [1:0] SZ_1     = 2'h0;
	localparam logic [1:0] SZ_2     = 2'h1;
	localparam logic [1:0] SZ_4     = 2'h3;
	localparam logic [1:0] LEFT_1   = 2'h0;
	localparam logic [1:0] LEFT_2   = 2'h1;
	localparam logic [1:0] LEFT_4   = 2'h3;
	localparam logic [1:0] ADDR_LAST = 2'h3;

	// ----------------------------------------------------------------
	// Minimum wait states per cycle kind
	// ----------------------------------------------------------------
	localparam logic [2:0] IO_RD_WAITS  = 3'h3;
	localparam logic [2:0] IO_WR_WAITS  = 3'h2;
	localparam logic [2:0] DMA_RD_WAITS = 3'h3;
	localparam logic [2:0] DMA_WR_WAITS = 3'h4;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int         CLK_PERIOD_NS  = 5;
	localparam int         IO_TIMEOUT_NS  = 10000;
	localparam int         IO_TIMEOUT_CYC = IO_TIMEOUT_NS / CLK_PERIOD_NS;
	localparam int         TO_W           = 12;

	// ----------------------------------------------------------------
	// DMA request serial frame
	// ----------------------------------------------------------------
	localparam logic [2:0] DRQ_BITS = 3'h4;

	// ----------------------------------------------------------------
	// Cycle decoder states
	// ----------------------------------------------------------------
	typedef enum logic [11:0] {
		ST_IDLE    = 12'h001,
		ST_CTYPE   = 12'h002,
		ST_ADDR    = 12'h004,
		ST_CHAN    = 12'h008,
		ST_SIZE    = 12'h010,
		ST_WDATA   = 12'h020,
		ST_TARIN1  = 12'h040,
		ST_TARIN2  = 12'h080,
		ST_SYNC    = 12'h100,
		ST_RDATA   = 12'h200,
		ST_TAROUT  = 12'h400,
		ST_IGNORE  = 12'h800
	} lpctf_state_t;

endpackage

/* File: design/lpctf_range.sv */
`timescale 1ns/1ps
// Address window compare for one enabled register block
module lpctf_range #(
	parameter int AW = 16
) (
	input  wire logic [AW-1:0] i_addr,   // Decoded address
	input  wire logic [AW-1:0] i_lo,     // First address of block
	input  wire logic [AW-1:0] i_hi,     // Last address of block
	input  wire logic          i_en,     // Block enabled
	output logic               o_hit     // Address falls in block
);

	// Inclusive window match
	assign o_hit = i_en && (i_addr >= i_lo) && (i_addr <= i_hi);

endmodule

/* File: design/lpctf_dreq_enc.sv */
`timescale 1ns/1ps
// Serial encoder for the DMA request line: start, channel, active
module lpctf_dreq_enc (
	input  wire logic       i_core_clk,  // Core clock
	input  wire logic       i_rst,       // Async reset, high
	input  wire logic       i_clear,     // Power-down clear
	input  wire logic       i_req,       // Requested level
	input  wire logic [2:0] i_channel,   // DMA channel
	output logic            o_dreq_n     // Encoded request line
);

	logic [5:0] shift_reg, shift_next;
	logic [2:0] cnt_reg, cnt_next;
	logic       sent_reg, sent_next;
	logic       dreq_reg, dreq_next;

	// Send a frame whenever the requested level differs from the sent one
	always_comb begin
		shift_next = shift_reg;
		cnt_next   = cnt_reg;
		sent_next  = sent_reg;
		dreq_next  = 1'b1;
		if (i_clear) begin
			cnt_next  = 3'h0;
			sent_next = 1'b0;
		end else if (cnt_reg != 3'h0) begin
			dreq_next  = shift_reg[5];
			shift_next = {shift_reg[4:0], 1'b1};
			cnt_next   = cnt_reg - 3'h1;
		end else if (dreq_reg && (i_req != sent_reg)) begin
			dreq_next  = 1'b0;
			shift_next = {i_channel, i_req, 2'h3};
			cnt_next   = lpctf_pkg::DRQ_BITS;
			sent_next  = i_req;
		end
	end

	// Line idles high from reset
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			shift_reg <= 6'h3F;
			cnt_reg   <= 3'h0;
			sent_reg  <= 1'b0;
			dreq_reg  <= 1'b1;
		end else begin
			shift_reg <= shift_next;
			cnt_reg   <= cnt_next;
			sent_reg  <= sent_next;
			dreq_reg  <= dreq_next;
		end
	end

	assign o_dreq_n = dreq_reg;

endmodule

/* File: design/lpctf_target.sv */
`timescale 1ns/1ps
module lpctf_target #(
	parameter int NBLK = 4
) (
	input  wire logic             i_core_clk,         // Core clock
	input  wire logic             i_rst,              // Bus reset, async, high
	input  wire logic [3:0]       i_lad,              // Address/data bus in
	output logic      [3:0]       o_lad,              // Address/data bus out
	output logic                  o_lad_oe,           // Address/data bus drive
	input  wire logic             i_frame_strobe_n,   // Cycle frame strobe
	output logic                  o_dma_request_n,    // Encoded DMA request
	output logic                  o_wake_event_n,     // Wake line value
	output logic                  o_wake_event_n_oe,  // Wake line drive
	input  wire logic             i_bus_powerdown_n,  // Bus power-down
	output logic                  o_pd_ready,         // Idle for power loss
	input  wire logic [NBLK-1:0]  i_blk_en,           // Block enables
	input  wire logic [NBLK*16-1:0] i_blk_lo,         // Block first addresses
	input  wire logic [NBLK*16-1:0] i_blk_hi,         // Block last addresses
	input  wire logic             i_wake_req,         // Wake request level
	input  wire logic             i_dma_req,          // DMA service wanted
	input  wire logic [2:0]       i_dma_channel,      // DMA channel
	output logic      [15:0]      o_addr,             // I/O address
	output logic      [7:0]       o_wdata,            // Byte toward device
	output logic                  o_wr_strobe,        // Byte delivered
	output logic                  o_rd_strobe,        // Byte wanted
	output logic                  o_is_dma,           // Access is DMA
	output logic                  o_dma_tc,           // Terminal count
	input  wire logic [7:0]       i_rdata,            // Byte from device
	input  wire logic             i_ready,            // Device ready
	input  wire logic             i_error             // Device failed access
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	lpctf_pkg::lpctf_state_t state_reg, state_next;
	logic [15:0]          addr_reg, addr_next;
	logic [7:0]           data_reg, data_next;
	logic [1:0]           nib_reg, nib_next;
	logic [1:0]           left_reg, left_next;
	logic [2:0]           wcnt_reg, wcnt_next;
	logic [lpctf_pkg::TO_W-1:0] to_reg, to_next;
	logic [3:0]           code_reg, code_next;
	logic                 dma_reg, dma_next;
	logic                 wr_reg, wr_next;
	logic                 tc_reg, tc_next;
	logic [3:0]           lad_reg, lad_next;
	logic                 oe_reg, oe_next;
	logic                 wstb_reg, wstb_next;
	logic                 rstb_reg, rstb_next;
	logic                 pd_reg, pd_next;
	logic                 wake_reg, wake_next;
	logic [NBLK-1:0]      hit;
	logic [15:0]          addr_full;
	logic                 dev_drives;
	logic [3:0]           wait_code;
	logic [2:0]           min_waits;
	logic                 io_timeout;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	assign addr_full = {addr_reg[11:0], i_lad};

	genvar g;
	generate
		for (g = 0; g < NBLK; g++) begin : g_blk
			lpctf_range #(.AW(16)) u_range (
				.i_addr (addr_full),
				.i_lo   (i_blk_lo[g*16 +: 16]),
				.i_hi   (i_blk_hi[g*16 +: 16]),
				.i_en   (i_blk_en[g]),
				.o_hit  (hit[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Per-cycle choices
	// ----------------------------------------------------------------
	// Target drives data on I/O read and DMA write
	assign dev_drives = (dma_reg == wr_reg);
	// short for DMA, long for I/O
	assign wait_code  = dma_reg ? lpctf_pkg::SYNC_SHORT : lpctf_pkg::SYNC_LONG;
	assign min_waits  = dma_reg ? (wr_reg ? lpctf_pkg::DMA_WR_WAITS : lpctf_pkg::DMA_RD_WAITS)
	                            : (wr_reg ? lpctf_pkg::IO_WR_WAITS : lpctf_pkg::IO_RD_WAITS);
	assign io_timeout = !dma_reg && (to_reg >= lpctf_pkg::IO_TIMEOUT_CYC[lpctf_pkg::TO_W-1:0]);

	// ----------------------------------------------------------------
	// Cycle decoder next state
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		addr_next  = addr_reg;
		data_next  = data_reg;
		nib_next   = nib_reg;
		left_next  = left_reg;
		wcnt_next  = wcnt_reg;
		to_next    = to_reg;
		code_next  = code_reg;
		dma_next   = dma_reg;
		wr_next    = wr_reg;
		tc_next    = tc_reg;
		wstb_next  = 1'b0;
		rstb_next  = 1'b0;
		if (!i_bus_powerdown_n) begin
			state_next = lpctf_pkg::ST_IDLE;
		end else if (!i_frame_strobe_n) begin
			// abort and watch for a start
			state_next = (i_lad == lpctf_pkg::START_NIB) ? lpctf_pkg::ST_CTYPE : lpctf_pkg::ST_IDLE;
		end else begin
			unique case (state_reg)
				lpctf_pkg::ST_IDLE: begin
				end
				lpctf_pkg::ST_CTYPE: begin
					dma_next = (i_lad[lpctf_pkg::CT_KIND_HI:lpctf_pkg::CT_KIND_LO] == lpctf_pkg::CT_DMA);
					wr_next  = i_lad[lpctf_pkg::CT_DIR_BIT];
					nib_next = 2'h0;
					left_next = lpctf_pkg::LEFT_1;
					if (i_lad[lpctf_pkg::CT_KIND_HI:lpctf_pkg::CT_KIND_LO] == lpctf_pkg::CT_IO) begin
						state_next = lpctf_pkg::ST_ADDR;
					end else if (i_lad[lpctf_pkg::CT_KIND_HI:lpctf_pkg::CT_KIND_LO] == lpctf_pkg::CT_DMA) begin
						state_next = lpctf_pkg::ST_CHAN;
					end else begin
						state_next = lpctf_pkg::ST_IGNORE;
					end
				end
				lpctf_pkg::ST_ADDR: begin
					addr_next = addr_full;
					nib_next  = nib_reg + 2'h1;
					if (nib_reg == lpctf_pkg::ADDR_LAST) begin
						nib_next = 2'h0;
						if (|hit) begin
							state_next = wr_reg ? lpctf_pkg::ST_WDATA : lpctf_pkg::ST_TARIN1;
						end else begin
							state_next = lpctf_pkg::ST_IGNORE;
						end
					end
				end
				lpctf_pkg::ST_CHAN: begin
					tc_next = i_lad[lpctf_pkg::CH_TC_BIT];
					if (i_dma_req && (i_lad[2:0] == i_dma_channel)) begin
						state_next = lpctf_pkg::ST_SIZE;
					end else begin
						state_next = lpctf_pkg::ST_IGNORE;
					end
				end
				lpctf_pkg::ST_SIZE: begin
					state_next = wr_reg ? lpctf_pkg::ST_TARIN1 : lpctf_pkg::ST_WDATA;
					nib_next   = 2'h0;
					unique case (i_lad[1:0])
						lpctf_pkg::SZ_1: left_next = lpctf_pkg::LEFT_1;
						lpctf_pkg::SZ_2: left_next = lpctf_pkg::LEFT_2;
						lpctf_pkg::SZ_4: left_next = lpctf_pkg::LEFT_4;
						default: state_next = lpctf_pkg::ST_IGNORE;
					endcase
				end
				lpctf_pkg::ST_WDATA: begin
					if (nib_reg == 2'h0) begin
						data_next[3:0] = i_lad;
						nib_next = 2'h1;
					end else begin
						data_next[7:4] = i_lad;
						nib_next = 2'h0;
						state_next = lpctf_pkg::ST_TARIN1;
					end
				end
				lpctf_pkg::ST_TARIN1: begin
					state_next = lpctf_pkg::ST_TARIN2;
				end
				lpctf_pkg::ST_TARIN2: begin
					// first wait code right after turnaround
					state_next = lpctf_pkg::ST_SYNC;
					code_next  = wait_code;
					wcnt_next  = min_waits - 3'h1;
					to_next    = '0;
					wstb_next  = !dev_drives;
					rstb_next  = dev_drives;
				end
				lpctf_pkg::ST_SYNC: begin
					if ((code_reg == lpctf_pkg::SYNC_SHORT) || (code_reg == lpctf_pkg::SYNC_LONG)) begin
						if (wcnt_reg != 3'h0) begin
							wcnt_next = wcnt_reg - 3'h1;
						end else if (i_ready) begin
							data_next = dev_drives ? i_rdata : data_reg;
							if (i_error) begin
								code_next = lpctf_pkg::SYNC_ERR;
							end else begin
								code_next = (left_reg != 2'h0) ? lpctf_pkg::SYNC_MORE : lpctf_pkg::SYNC_READY;
							end
						end else if (io_timeout) begin
							code_next = lpctf_pkg::SYNC_ERR;
						end else begin
							to_next = to_reg + 1'b1;
						end
					end else begin
						// data follows the ready code at once
						nib_next = 2'h0;
						if (dev_drives && !(dma_reg && (code_reg == lpctf_pkg::SYNC_ERR))) begin
							state_next = lpctf_pkg::ST_RDATA;
						end else if (code_reg == lpctf_pkg::SYNC_MORE) begin
							left_next  = left_reg - 2'h1;
							state_next = lpctf_pkg::ST_WDATA;
						end else begin
							state_next = lpctf_pkg::ST_TAROUT;
						end
					end
				end
				lpctf_pkg::ST_RDATA: begin
					nib_next = nib_reg + 2'h1;
					if (nib_reg != 2'h0) begin
						if (code_reg == lpctf_pkg::SYNC_MORE) begin
							left_next  = left_reg - 2'h1;
							state_next = lpctf_pkg::ST_SYNC;
							code_next  = wait_code;
							wcnt_next  = min_waits - 3'h1;
							rstb_next  = 1'b1;
						end else begin
							state_next = lpctf_pkg::ST_TAROUT;
						end
					end
				end
				lpctf_pkg::ST_TAROUT: begin
					state_next = lpctf_pkg::ST_IDLE;
				end
				lpctf_pkg::ST_IGNORE: begin
					// no own timer; wait for the next frame
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Pin drive, registered from the next state
	// ----------------------------------------------------------------
	always_comb begin
		lad_next = lpctf_pkg::TAR_NIB;
		oe_next  = 1'b0;
		unique case (state_next)
			lpctf_pkg::ST_SYNC: begin
				lad_next = code_next;
				oe_next  = 1'b1;
			end
			lpctf_pkg::ST_RDATA: begin
				lad_next = (nib_next == 2'h0) ? data_next[3:0] : data_next[7:4];
				oe_next  = 1'b1;
			end
			lpctf_pkg::ST_TAROUT: begin
				oe_next  = 1'b1;
			end
			default: begin
			end
		endcase
		pd_next   = !i_bus_powerdown_n && (state_next == lpctf_pkg::ST_IDLE);
		// drive low only to request wake
		wake_next = i_wake_req;
	end

	// reset floats the bus; no clock-run logic exists
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			state_reg <= lpctf_pkg::ST_IDLE;
			addr_reg  <= 16'h0000;
			data_reg  <= 8'h00;
			nib_reg   <= 2'h0;
			left_reg  <= 2'h0;
			wcnt_reg  <= 3'h0;
			to_reg    <= '0;
			code_reg  <= lpctf_pkg::SYNC_READY;
			dma_reg   <= 1'b0;
			wr_reg    <= 1'b0;
			tc_reg    <= 1'b0;
			lad_reg   <= lpctf_pkg::TAR_NIB;
			oe_reg    <= 1'b0;
			wstb_reg  <= 1'b0;
			rstb_reg  <= 1'b0;
			pd_reg    <= 1'b0;
			wake_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			addr_reg  <= addr_next;
			data_reg  <= data_next;
			nib_reg   <= nib_next;
			left_reg  <= left_next;
			wcnt_reg  <= wcnt_next;
			to_reg    <= to_next;
			code_reg  <= code_next;
			dma_reg   <= dma_next;
			wr_reg    <= wr_next;
			tc_reg    <= tc_next;
			lad_reg   <= lad_next;
			oe_reg    <= oe_next;
			wstb_reg  <= wstb_next;
			rstb_reg  <= rstb_next;
			pd_reg    <= pd_next;
			wake_reg  <= wake_next;
		end
	end

	// ----------------------------------------------------------------
	// DMA request line
	// ----------------------------------------------------------------
	// encoded request, high in reset and power-down
	lpctf_dreq_enc u_dreq (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_clear    (!i_bus_powerdown_n),
		.i_req      (i_dma_req),
		.i_channel  (i_dma_channel),
		.o_dreq_n   (o_dma_request_n)
	);

	// Outputs
	assign o_lad             = lad_reg;
	assign o_lad_oe          = oe_reg;
	assign o_wake_event_n    = 1'b0;
	assign o_wake_event_n_oe = wake_reg;
	assign o_pd_ready        = pd_reg;
	assign o_addr            = addr_reg;
	assign o_wdata           = data_reg;
	assign o_wr_strobe       = wstb_reg;
	assign o_rd_strobe       = rstb_reg;
	assign o_is_dma          = dma_reg;
	assign o_dma_tc          = tc_reg;

endmodule

/* File: test/lpctf_target_properties.sv */
`timescale 1ns/1ps
// Timing checks on the target's bus, request and side pins
module lpctf_target_properties (
	input wire logic       i_core_clk,        // Core clock
	input wire logic       i_rst,             // Bus reset
	input wire logic       i_frame_strobe_n,  // Frame strobe
	input wire logic       i_bus_powerdown_n, // Power-down
	input wire logic       i_wake_req,        // Wake wanted
	input wire logic       i_dma_req,         // DMA wanted
	input wire logic [2:0] i_dma_channel,     // DMA channel
	input wire logic [3:0] o_lad,             // Bus out
	input wire logic       o_lad_oe,          // Bus drive
	input wire logic       o_dma_request_n,   // Encoded request
	input wire logic       o_wake_event_n,    // Wake value
	input wire logic       o_wake_event_n_oe, // Wake drive
	input wire logic       o_pd_ready,        // Ready for power loss
	input wire logic       o_rd_strobe,       // Byte wanted
	input wire logic       o_is_dma           // DMA cycle
);
	// ------------------------------------------
	// Bus handshake
	// ------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	a_frame_release: assert property (!i_frame_strobe_n |=> !o_lad_oe)
		else $error("bus held after frame strobe");
	a_reset_quiet: assert property ($past(i_rst) |-> !o_lad_oe && o_dma_request_n && !o_wake_event_n_oe)
		else $error("pins active out of reset");
	a_io_read_waits: assert property ($rose(o_lad_oe) && o_rd_strobe && !o_is_dma |-> (o_lad == 4'h6)[*3])
		else $error("too few read waits");
	a_io_long_code: assert property ($rose(o_lad_oe) && !o_is_dma |-> (o_lad == 4'h6)[*2])
		else $error("wrong wait code on io");
	a_dma_short_code: assert property ($rose(o_lad_oe) && o_is_dma |-> (o_lad == 4'h5)[*3])
		else $error("wrong wait code on dma");
	a_wait_no_mix: assert property ((o_lad_oe && !o_is_dma && o_lad == 4'h6)[*2] |=>
		!(o_lad_oe && o_lad == 4'h5))
		else $error("wait codes mixed");
	a_read_sync_start: assert property (o_rd_strobe && !o_is_dma |-> $rose(o_lad_oe))
		else $error("read handshake late");

	// ------------------------------------------
	// Side pins
	// ------------------------------------------
	a_wake_follow: assert property (1'b1 |-> o_wake_event_n_oe == $past(i_wake_req) && !o_wake_event_n)
		else $error("wake line wrong");
	a_pd_ready: assert property ((!i_bus_powerdown_n && i_frame_strobe_n)[*4] |-> o_pd_ready && !o_lad_oe)
		else $error("not ready for power loss");
	a_dreq_frame: assert property (o_dma_request_n[*6] ##1 !o_dma_request_n |=>
		o_dma_request_n == i_dma_channel[2] ##1 o_dma_request_n == i_dma_channel[1]
		##1 o_dma_request_n == i_dma_channel[0] ##1 o_dma_request_n == i_dma_req)
		else $error("request frame wrong");
endmodule

/* File: test/lpctf_host_model.sv */
`timescale 1ns/1ps
// Host controller model: frames cycles, turns the bus round, reads handshakes
module lpctf_host_model (
	input  wire logic       i_core_clk, // Bus clock
	input  wire logic [3:0] i_lad,      // Resolved bus
	input  wire logic       i_tgt_oe,   // Target drives bus
	output logic      [3:0] o_lad,      // Host bus value
	output logic            o_lad_oe,   // Host drives bus
	output logic            o_frame_n   // Frame strobe
);
	initial begin
		o_lad = 4'hF;
		o_lad_oe = 1'b0;
		o_frame_n = 1'b1;
	end

	// Drive one nibble for one clock
	task automatic put(input logic [3:0] n);
		o_lad <= n;
		o_lad_oe <= 1'b1;
		@(posedge i_core_clk);
	endtask

	task automatic abort();
		o_frame_n <= 1'b0;
		put(4'hF);
		o_frame_n <= 1'b1;
		o_lad_oe <= 1'b0;
	endtask

	// abort on three silent clocks in a row
	task automatic get_sync(input int stop, output logic [3:0] code, output int waits, output logic [3:0] wc);
		int miss;
		miss = 0;
		waits = 0;
		wc = 4'hF;
		code = 4'hF;
		while (code === 4'hF) begin
			@(posedge i_core_clk);
			if (i_tgt_oe === 1'b1 && (i_lad == 4'h5 || i_lad == 4'h6)) begin
				waits++;
				wc = i_lad;
				miss = 0;
			end else if (i_tgt_oe === 1'b1 && i_lad inside {4'h0, 4'h9, 4'hA})
				code = i_lad;
			else
				miss++;
			if (miss == 3 || (stop != 0 && waits == stop)) begin
				abort();
				return;
			end
		end
	endtask

	task automatic xfer(input logic [3:0] ct, input logic [15:0] adr, input logic [1:0] sz, input logic [31:0] wd,
			input int stop, output logic [15:0] syn, output logic [31:0] rd, output int waits, output logic [3:0] wc);
		logic [3:0] code;
		int         nb;
		bit         hd;
		hd = (ct == 4'h2) || (ct == 4'h8);
		nb = ct[3] ? ((sz == 2'h3) ? 4 : sz + 1) : 1;
		syn = 16'hFFFF;
		rd = 32'h0;
		@(posedge i_core_clk);
		o_frame_n <= 1'b0;
		put(4'h0);
		o_frame_n <= 1'b1;
		put(ct);
		if (ct[3]) begin
			put(adr[3:0]);
			put({2'h0, sz});
		end else
			for (int i = 3; i >= 0; i--)
				put(adr[i*4 +: 4]);
		for (int b = 0; b < nb; b++) begin
			if (hd) begin
				put(wd[b*8 +: 4]);
				put(wd[b*8+4 +: 4]);
			end
			if (hd || b == 0) begin
				put(4'hF);
				put(4'hF);
				o_lad_oe <= 1'b0;
			end
			get_sync(stop, code, waits, wc);
			syn[b*4 +: 4] = code;
			if (!hd && code != 4'hF && !(ct[3] && code == 4'hA)) begin
				@(posedge i_core_clk);
				rd[b*8 +: 4] = i_lad;
				@(posedge i_core_clk);
				rd[b*8+4 +: 4] = i_lad;
			end
			if (code != 4'h9)
				break;
		end
		repeat (3) @(posedge i_core_clk);
	endtask
endmodule

/* File: test/lpctf_target_tb_top.sv */
`timescale 1ns/1ps
// Self-checking bench for the bus target
module lpctf_target_tb_top;
	logic        clk, rst, t_oe, h_oe, frame_n, pd_n, wake, dreq, ready, err;
	logic        wake_n, wake_oe, dreq_n, pd_rdy, wr_stb, rd_stb, is_dma, tc;
	logic [3:0]  lad, t_lad, h_lad, blk_en, wc;
	logic [2:0]  dch;
	logic [7:0]  rdata, wdata, last_wd;
	logic [15:0] addr, syn;
	logic [31:0] rd;
	logic [63:0] blk_lo, blk_hi;
	int          w, n_mismatch, checked;
	int          n_rd = 0;

	// Pull-ups hold the bus high when nobody drives
	assign lad = h_oe ? h_lad : (t_oe ? t_lad : 4'hF);

	lpctf_host_model host_u (.i_core_clk(clk), .i_lad(lad), .i_tgt_oe(t_oe), .o_lad(h_lad), .o_lad_oe(h_oe),
		.o_frame_n(frame_n));
	lpctf_target #(.NBLK(4)) dut_u (.i_core_clk(clk), .i_rst(rst), .i_lad(lad), .o_lad(t_lad), .o_lad_oe(t_oe),
		.i_frame_strobe_n(frame_n), .o_dma_request_n(dreq_n), .o_wake_event_n(wake_n),
		.o_wake_event_n_oe(wake_oe), .i_bus_powerdown_n(pd_n), .o_pd_ready(pd_rdy), .i_blk_en(blk_en),
		.i_blk_lo(blk_lo), .i_blk_hi(blk_hi), .i_wake_req(wake), .i_dma_req(dreq), .i_dma_channel(dch),
		.o_addr(addr), .o_wdata(wdata), .o_wr_strobe(wr_stb), .o_rd_strobe(rd_stb), .o_is_dma(is_dma),
		.o_dma_tc(tc), .i_rdata(rdata), .i_ready(ready), .i_error(err));

	// Clock at 200 MHz
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Keep the last byte handed to the device
	always @(posedge clk)
		if (wr_stb === 1'b1)
			last_wd <= wdata;

	// Count bytes asked of the device
	always @(posedge clk)
		if (rd_stb === 1'b1)
			n_rd <= n_rd + 1;

	// ------------------------------------------
	// Helpers
	// ------------------------------------------
	task automatic chk(input logic ok, input string what);
		checked++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("[ERR] %0t %s", $time, what);
		end
	endtask

	task automatic run(input logic [3:0] ct, input logic [15:0] a, input logic [1:0] sz, input logic [31:0] d, input int s);
		host_u.xfer(ct, a, sz, d, s, syn, rd, w, wc);
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ------------------------------------------
	// Scenarios
	// ------------------------------------------
	task automatic t_io();
		run(4'h0, 16'h03FA, 2'h0, 32'h0, 0);
		chk(syn[3:0] === 4'h0 && w == 3 && wc === 4'h6, "io read waits");
		chk(rd[7:0] === 8'hA5 && addr === 16'h03FA && is_dma === 1'b0, "io read byte");
		run(4'h2, 16'h0064, 2'h0, 32'h3C, 0);
		chk(syn[3:0] === 4'h0 && w == 2 && last_wd === 8'h3C, "io write");
		ready <= 1'b0;
		fork
			run(4'h0, 16'h03F8, 2'h0, 32'h0, 0);
			begin
				repeat (60) @(posedge clk);
				ready <= 1'b1;
			end
		join
		chk(syn[3:0] === 4'h0 && w > 3 && wc === 4'h6, "stretched read");
		ready <= 1'b0;
		run(4'h0, 16'h03F8, 2'h0, 32'h0, 0);
		chk(syn[3:0] === 4'hA && w >= 1990 && w <= 2010, "io timeout");
		run(4'h0, 16'h0060, 2'h0, 32'h0, 5);
		chk(syn[3:0] === 4'hF && t_oe === 1'b0, "abort release");
		ready <= 1'b1;
		$display("test io done");
	endtask

	task automatic t_ign();
		logic [3:0]  cts [3] = '{4'h0, 4'h0, 4'h4};
		logic [15:0] ads [3] = '{16'h0278, 16'h0065, 16'h03F8};
		for (int i = 0; i < 3; i++) begin
			run(cts[i], ads[i], 2'h0, 32'h0, 0);
			chk(syn[3:0] === 4'hF, "unclaimed cycle answered");
		end
		$display("test ignore done");
	endtask

	task automatic t_dma();
		int k;
		dreq <= 1'b1;
		repeat (12) @(posedge clk);
		run(4'h8, 16'h0002, 2'h1, 32'hB7A4, 0);
		chk(syn[7:0] === 8'h09 && last_wd === 8'hB7 && w == 3 && wc === 4'h5, "dma read");
		chk(tc === 1'b0 && is_dma === 1'b1, "dma kind");
		rdata <= 8'h5E;
		k = n_rd;
		run(4'hA, 16'h000A, 2'h3, 32'h0, 0);
		chk(syn === 16'h0999 && rd === 32'h5E5E5E5E && w == 4, "dma write");
		chk(tc === 1'b1 && n_rd - k == 4, "dma count and strobes");
		err <= 1'b1;
		run(4'hA, 16'h0002, 2'h3, 32'h0, 0);
		chk(syn === 16'hFFFA, "dma error end");
		err <= 1'b0;
		run(4'h8, 16'h0003, 2'h0, 32'h0, 0);
		chk(syn[3:0] === 4'hF, "other channel");
		run(4'h8, 16'h0002, 2'h2, 32'h0, 0);
		chk(syn[3:0] === 4'hF, "reserved size");
		dreq <= 1'b0;
		repeat (12) @(posedge clk);
		$display("test dma done");
	endtask

	task automatic t_side();
		wake <= 1'b1;
		repeat (2) @(posedge clk);
		chk(wake_oe === 1'b1 && wake_n === 1'b0, "wake pull");
		wake <= 1'b0;
		pd_n <= 1'b0;
		repeat (6) @(posedge clk);
		chk(pd_rdy === 1'b1 && t_oe === 1'b0 && dreq_n === 1'b1 && wake_oe === 1'b0, "powerdown");
		pd_n <= 1'b1;
		repeat (2) @(posedge clk);
		$display("test side pins done");
	endtask

	// Cut a hung run short
	initial begin
		#100us;
		n_mismatch++;
		report_and_stop();
	end

	// Reset, then the scenarios
	initial begin
		n_mismatch = 0;
		checked = 0;
		rst = 1'b1;
		pd_n = 1'b1;
		wake = 1'b0;
		dreq = 1'b0;
		dch = 3'h2;
		rdata = 8'hA5;
		ready = 1'b1;
		err = 1'b0;
		blk_en = 4'h3;
		blk_lo = {16'h0000, 16'h0278, 16'h03F8, 16'h0060};
		blk_hi = {16'h0000, 16'h027F, 16'h03FF, 16'h0064};
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_io();
		t_ign();
		t_dma();
		t_side();
		report_and_stop();
	end
endmodule

bind lpctf_target lpctf_target_properties chk_u (.i_core_clk(i_core_clk), .i_rst(i_rst),
	.i_frame_strobe_n(i_frame_strobe_n), .i_bus_powerdown_n(i_bus_powerdown_n), .i_wake_req(i_wake_req),
	.i_dma_req(i_dma_req), .i_dma_channel(i_dma_channel), .o_lad(o_lad), .o_lad_oe(o_lad_oe),
	.o_dma_request_n(o_dma_request_n), .o_wake_event_n(o_wake_event_n), .o_wake_event_n_oe(o_wake_event_n_oe),
	.o_pd_ready(o_pd_ready), .o_rd_strobe(o_rd_strobe), .o_is_dma(o_is_dma));
